// file: core/floppy_seek_status_cmds.sv
// Command interpreter for seek, recalibrate and sense commands
`timescale 1ns/1ps
module floppy_seek_status_cmds (
    input  wire logic       sys_clk,          // System clock, 125 MHz
    input  wire logic       rst,              // Asynchronous reset, active high
    input  wire logic       ce,               // Clock enable, freezes all state when low
    input  wire logic       host_wr_valid,    // Host offers a command or parameter byte
    input  wire logic [7:0] host_wr_data,     // Command or parameter byte
    output logic            host_wr_ready,    // Byte can be taken
    output logic            res_valid,        // Result byte available
    output logic      [7:0] res_data,         // Current result byte
    input  wire logic       res_rd,           // Host pops the result byte
    output logic            int_out,          // Seek or recalibrate finished
    output logic      [3:0] drive_busy,       // Per-drive seek busy
    output logic            step_out,         // Head step pulse
    output logic            dir_out,          // Step direction, high steps inward
    output logic      [1:0] drive_sel,        // Drive being positioned
    input  wire logic       trk0_pin,         // Track zero from drive
    input  wire logic       wprot_pin,        // Write protect from drive
    input  wire logic       ready_pin,        // Ready from drive
    input  wire logic       twosd_pin,        // Two sided from drive
    input  wire logic       xfer_seek_req,    // Transfer logic asks for an implied seek
    input  wire logic [1:0] xfer_seek_drive,  // Drive for implied seek
    input  wire logic [7:0] xfer_seek_cyl,    // Cylinder for implied seek
    output logic            xfer_seek_done,   // Implied seek finished or skipped, one cycle
    output logic            implied_seek_enable // Configured implied seek enable
);
    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_PARAM  = 3'b001,
        S_EXEC   = 3'b011,
        S_WAIT   = 3'b010,
        S_RESULT = 3'b110
    } fsm_e;

    typedef struct packed {
        fsm_e            fsm;
        logic [7:0]      op;
        logic [1:0]      npar;
        logic [1:0]      drv;
        logic            head;
        logic [7:0]      target;
        logic [3:0][7:0] cyl;
        logic            pend;
        logic [7:0]      stat;
        logic [7:0]      stat_cyl;
        logic [1:0][7:0] rbuf;
        logic [1:0]      rcnt;
        logic            ridx;
        logic            imp_en;
        logic [9:0]      timer;
        logic [7:0]      nsteps;
        logic            recal;
        logic            implied;
        logic            step;
        logic            dir;
        logic [3:0]      busy;
        logic            irq;
        logic            done;
        logic            wr_ready;
        logic            rvalid;
        logic [7:0]      rdata;
    } core_s;

    core_s      st_q;
    core_s      st_d;
    logic [3:0] pins_s;

    // Number of parameter bytes after a code; 0 for none or unknown
    function automatic logic [1:0] par_count(input logic [7:0] op);
        case (op)
            fdc_seek_pkg::OP_SPECIFY:   par_count = fdc_seek_pkg::NPAR_SPECIFY;
            fdc_seek_pkg::OP_SDS:       par_count = fdc_seek_pkg::NPAR_SDS;
            fdc_seek_pkg::OP_RECAL:     par_count = fdc_seek_pkg::NPAR_RECAL;
            fdc_seek_pkg::OP_SEEK:      par_count = fdc_seek_pkg::NPAR_SEEK;
            fdc_seek_pkg::OP_CONFIGURE: par_count = fdc_seek_pkg::NPAR_CONFIGURE;
            default:                    par_count = 2'h0;
        endcase
    endfunction : par_count

    // True for codes this block knows
    function automatic logic known_op(input logic [7:0] op);
        known_op = (par_count(op) != 2'h0) || (op == fdc_seek_pkg::OP_SIS);
    endfunction : known_op

    // Drive pins, filtered against metastability and bounce
    pin_sync3 #(.W(4)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .d       ({twosd_pin, ready_pin, wprot_pin, trk0_pin}),
        .q       (pins_s)
    );

    logic wr_take;
    logic rd_take;
    assign wr_take = host_wr_valid && st_q.wr_ready;
    assign rd_take = res_rd && st_q.rvalid;

    // Next-state logic
    always_comb
    begin
        st_d      = st_q;
        st_d.done = 1'b0;
        case (st_q.fsm)
            S_IDLE:
            begin
                if (wr_take)
                begin
                    st_d.op   = host_wr_data;
                    st_d.npar = par_count(host_wr_data);
                    if (host_wr_data == fdc_seek_pkg::OP_SIS)
                    begin
                        // Report last seek end, then clear it
                        st_d.rbuf[0] = st_q.pend ? st_q.stat : fdc_seek_pkg::STAT_INVALID;
                        st_d.rbuf[1] = st_q.stat_cyl;
                        st_d.rcnt    = st_q.pend ? 2'h2 : 2'h1;
                        st_d.pend    = 1'b0;
                        st_d.irq     = 1'b0;
                        st_d.fsm     = S_RESULT;
                    end
                    else if (!known_op(host_wr_data))
                    begin
                        st_d.rbuf[0] = fdc_seek_pkg::STAT_INVALID;
                        st_d.rcnt    = 2'h1;
                        st_d.fsm     = S_RESULT;
                    end
                    else
                    begin
                        st_d.fsm = S_PARAM;
                    end
                end
                else if (xfer_seek_req)
                begin
                    st_d.done = !st_q.imp_en;
                    if (st_q.imp_en)
                    begin
                        st_d.drv     = xfer_seek_drive;
                        st_d.target  = xfer_seek_cyl;
                        st_d.implied = 1'b1;
                        st_d.recal   = 1'b0;
                        st_d.busy[xfer_seek_drive] = 1'b1;
                        st_d.fsm     = S_EXEC;
                    end
                end
            end
            S_PARAM:
            begin
                if (wr_take)
                begin
                    st_d.npar = st_q.npar - 2'h1;
                    case (st_q.op)
                        fdc_seek_pkg::OP_CONFIGURE:
                        begin
                            if (st_q.npar == 2'h2)
                            begin
                                st_d.imp_en = host_wr_data[fdc_seek_pkg::CFG_IMPLIED_BIT];
                            end
                        end
                        fdc_seek_pkg::OP_SEEK, fdc_seek_pkg::OP_RECAL,
                        fdc_seek_pkg::OP_SDS:
                        begin
                            if (st_q.npar == par_count(st_q.op))
                            begin
                                st_d.drv  = host_wr_data[1:0];
                                st_d.head = host_wr_data[fdc_seek_pkg::SEL_HEAD_BIT];
                            end
                            else
                            begin
                                st_d.target = host_wr_data;
                            end
                        end
                        default:
                        begin
                        end
                    endcase
                    if (st_q.npar == 2'h1)
                    begin
                        st_d.fsm = S_IDLE;
                        if (st_q.op == fdc_seek_pkg::OP_SDS)
                        begin
                            // One byte of drive condition
                            st_d.rbuf[0] = {1'b0, pins_s[1], pins_s[2], pins_s[0], pins_s[3],
                                            st_d.head, st_d.drv};
                            st_d.rcnt    = 2'h1;
                            st_d.fsm     = S_RESULT;
                        end
                        else if (st_q.op == fdc_seek_pkg::OP_SEEK ||
                                 st_q.op == fdc_seek_pkg::OP_RECAL)
                        begin
                            st_d.recal   = (st_q.op == fdc_seek_pkg::OP_RECAL);
                            st_d.implied = 1'b0;
                            st_d.nsteps  = fdc_seek_pkg::BYTE_ZERO;
                            st_d.busy[st_d.drv] = 1'b1;
                            st_d.fsm     = S_EXEC;
                        end
                    end
                end
            end
            S_EXEC:
            begin
                if (st_q.recal ? pins_s[0] : (st_q.cyl[st_q.drv] == st_q.target))
                begin
                    // Arrived; recalibrate zeroes the cylinder
                    if (st_q.recal)
                    begin
                        st_d.cyl[st_q.drv] = fdc_seek_pkg::CYL_RESET;
                    end
                    st_d.busy[st_q.drv] = 1'b0;
                    st_d.fsm = S_IDLE;
                    if (st_q.implied)
                    begin
                        st_d.done = 1'b1;
                    end
                    else
                    begin
                        st_d.pend    = 1'b1;
                        st_d.irq     = 1'b1;
                        st_d.stat     = fdc_seek_pkg::STAT_SEEK_END | {5'h00, st_q.head, st_q.drv};
                        st_d.stat_cyl = st_d.cyl[st_q.drv];
                    end
                end
                else if (st_q.recal && st_q.nsteps == fdc_seek_pkg::RECAL_STEP_LIMIT)
                begin
                    // Track zero never seen: abnormal end with equipment check
                    st_d.busy[st_q.drv] = 1'b0;
                    st_d.pend    = 1'b1;
                    st_d.irq     = 1'b1;
                    st_d.stat     = fdc_seek_pkg::STAT_ABNORMAL | fdc_seek_pkg::STAT_SEEK_END |
                                    fdc_seek_pkg::STAT_EQUIP | {5'h00, st_q.head, st_q.drv};
                    st_d.stat_cyl = st_q.cyl[st_q.drv];
                    st_d.fsm     = S_IDLE;
                end
                else
                begin
                    // Issue one step and track the head position
                    st_d.dir    = !st_q.recal && (st_q.target > st_q.cyl[st_q.drv]);
                    st_d.cyl[st_q.drv] = st_d.dir ? st_q.cyl[st_q.drv] + 8'h01
                                                  : st_q.cyl[st_q.drv] - 8'h01;
                    st_d.nsteps = st_q.nsteps + 8'h01;
                    st_d.step   = 1'b1;
                    st_d.timer  = fdc_seek_pkg::STEP_CYC_W;
                    st_d.fsm    = S_WAIT;
                end
            end
            S_WAIT:
            begin
                st_d.timer = st_q.timer - 10'h001;
                if (st_q.timer == fdc_seek_pkg::PULSE_END_W)
                begin
                    st_d.step = 1'b0;
                end
                if (st_q.timer == fdc_seek_pkg::TIMER_ZERO)
                begin
                    st_d.fsm = S_EXEC;
                end
            end
            S_RESULT:
            begin
                if (rd_take)
                begin
                    st_d.ridx = 1'b1;
                    if (st_q.rcnt == 2'h1 || st_q.ridx)
                    begin
                        st_d.ridx = 1'b0;
                        st_d.fsm  = S_IDLE;
                    end
                end
            end
            default:
            begin
                st_d.fsm = S_IDLE;
            end
        endcase
        // Registered handshake outputs follow the next state
        st_d.wr_ready = (st_d.fsm == S_IDLE) || (st_d.fsm == S_PARAM);
        st_d.rvalid   = (st_d.fsm == S_RESULT);
        st_d.rdata    = st_d.rbuf[st_d.ridx];
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q          <= '0;
            st_q.fsm      <= S_IDLE;
            st_q.wr_ready <= 1'b1;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign host_wr_ready       = st_q.wr_ready;
    assign res_valid           = st_q.rvalid;
    assign res_data            = st_q.rdata;
    assign int_out             = st_q.irq;
    assign drive_busy          = st_q.busy;
    assign step_out            = st_q.step;
    assign dir_out             = st_q.dir;
    assign drive_sel           = st_q.drv;
    assign xfer_seek_done      = st_q.done;
    assign implied_seek_enable = st_q.imp_en;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    recal_track_zero_a: assert property (ce && st_q.fsm == S_EXEC && st_q.recal && pins_s[0]
        |=> st_q.cyl[$past(st_q.drv)] == 8'h00 && st_q.irq && st_q.fsm == S_IDLE)
        else $error("recalibrate end did not zero cylinder and interrupt");
    sense_int_pair_a: assert property (ce && wr_take && st_q.fsm == S_IDLE
        && host_wr_data == 8'h08 && st_q.pend
        |=> st_q.rvalid && st_q.rcnt == 2'h2 && st_q.rdata == $past(st_q.stat) && !st_q.irq)
        else $error("sense interrupt did not return two status bytes");
    drive_status_one_a: assert property (ce && wr_take && st_q.fsm == S_PARAM
        && st_q.op == 8'h04 && st_q.npar == 2'h1 |=> st_q.rvalid && st_q.rcnt == 2'h1)
        else $error("sense drive status did not give one byte");
    seek_arrive_a: assert property (ce && st_q.fsm == S_EXEC && !st_q.recal
        && st_q.cyl[st_q.drv] == st_q.target |=> st_q.fsm == S_IDLE && st_q.busy == 4'h0)
        else $error("seek did not end on target cylinder");
    invalid_code_a: assert property (ce && wr_take && st_q.fsm == S_IDLE
        && !known_op(host_wr_data) && host_wr_data != 8'h08
        |=> st_q.rvalid && st_q.rdata == 8'h80 && st_q.rcnt == 2'h1)
        else $error("unknown code did not return 80 hex");
    seek_busy_a: assert property ((st_q.fsm == S_EXEC || st_q.fsm == S_WAIT)
        |-> st_q.busy[st_q.drv])
        else $error("drive busy dropped during seek");
    implied_gate_a: assert property (ce && st_q.fsm == S_IDLE && !wr_take
        && xfer_seek_req && !st_q.imp_en |=> st_q.fsm == S_IDLE && st_q.done && st_q.busy == 4'h0)
        else $error("implied seek ran while disabled");
    result_lock_a: assert property (st_q.rvalid |-> !st_q.wr_ready)
        else $error("command accepted before results read");
    step_width_a: assert property (ce && $rose(st_q.step) |-> st_q.step [*8])
        else $error("step pulse too short");

    seek_run_c:   cover property (st_q.fsm == S_EXEC && !st_q.recal && st_q.step == 1'b0);
    recal_fail_c: cover property (st_q.pend && st_q.stat[6]);
    implied_c:    cover property (st_q.done && st_q.imp_en);
endmodule : floppy_seek_status_cmds

// file: core/fdc_seek_pkg.sv
// Constants for the drive positioning and status command interpreter
package fdc_seek_pkg;
    // Command codes
    localparam logic [7:0] OP_SPECIFY   = 8'h03;
    localparam logic [7:0] OP_SDS       = 8'h04;
    localparam logic [7:0] OP_RECAL     = 8'h07;
    localparam logic [7:0] OP_SIS       = 8'h08;
    localparam logic [7:0] OP_SEEK      = 8'h0F;
    localparam logic [7:0] OP_CONFIGURE = 8'h13;
    // Parameter byte counts
    localparam logic [1:0] NPAR_SPECIFY   = 2'h2;
    localparam logic [1:0] NPAR_SDS       = 2'h1;
    localparam logic [1:0] NPAR_RECAL     = 2'h1;
    localparam logic [1:0] NPAR_SEEK      = 2'h2;
    localparam logic [1:0] NPAR_CONFIGURE = 2'h3;
    // Field positions in select and configure bytes
    localparam int SEL_HEAD_BIT = 2;
    localparam int CFG_IMPLIED_BIT = 6;
    // Status byte zero fields
    localparam logic [7:0] STAT_INVALID  = 8'h80;
    localparam logic [7:0] STAT_ABNORMAL = 8'h40;
    localparam logic [7:0] STAT_SEEK_END = 8'h20;
    localparam logic [7:0] STAT_EQUIP    = 8'h10;
    // Drive status byte bit positions
    localparam int DS_WPROT_BIT = 6;
    localparam int DS_READY_BIT = 5;
    localparam int DS_TRK0_BIT  = 4;
    localparam int DS_TWOSD_BIT = 3;
    // Reset values
    localparam logic [7:0] CYL_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Recalibrate gives up after this many steps
    localparam logic [7:0] RECAL_STEP_LIMIT = 8'h50;
    // Step timing
    localparam int CLK_MHZ       = 125;
    localparam int STEP_RATE_US  = 3;
    localparam int STEP_PULSE_US = 1;
    localparam int STEP_CYC      = STEP_RATE_US * CLK_MHZ;
    localparam int PULSE_CYC     = STEP_PULSE_US * CLK_MHZ;
    localparam logic [9:0] STEP_CYC_W  = 10'(STEP_CYC - 1);
    localparam logic [9:0] PULSE_END_W = 10'(STEP_CYC - PULSE_CYC);
    localparam logic [9:0] TIMER_ZERO  = 10'h000;
endpackage : fdc_seek_pkg

// file: core/pin_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 4
) (
    input  wire logic         sys_clk, // System clock
    input  wire logic         rst,     // Asynchronous reset, active high
    input  wire logic         ce,      // Clock enable
    input  wire logic [W-1:0] d,       // Raw pin levels
    output logic      [W-1:0] q        // Filtered levels
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    // Shift chain; output follows once stages two and three agree
    always_comb
    begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_q.s2[i] == st_q.s3[i])
            begin
                st_d.q[i] = st_q.s3[i];
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign q = st_q.q;
endmodule : pin_sync3

// file: tb/drive_model.sv
// Floppy drive mechanics model that follows step pulses and reports track zero
`timescale 1ns/1ps
module drive_model (
    input  wire logic        sys_clk,   // System clock
    input  wire logic        rst,       // Reset, active high
    input  wire logic        step_out,  // Step pulse from block
    input  wire logic        dir_out,   // Direction, high steps inward
    input  wire logic [1:0]  drive_sel, // Drive being positioned
    output logic             trk0_pin,  // Selected head sits on cylinder zero
    output logic      [7:0]  cyl0,      // Head position of drive zero
    output logic      [15:0] step_cnt   // Step pulses seen
);
    logic [7:0] cyl_q [4];
    logic       step_q;

    // Move the selected head one cylinder on each rising step edge, except outward from cylinder zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cyl_q    <= '{4{8'h00}};
            step_q   <= 1'b0;
            step_cnt <= 16'h0000;
        end
        else
        begin
            step_q <= step_out;
            if (step_out && !step_q)
            begin
                step_cnt <= step_cnt + 16'h0001;
                if (dir_out)
                    cyl_q[drive_sel] <= cyl_q[drive_sel] + 8'h01;
                else if (cyl_q[drive_sel] != 8'h00)
                    cyl_q[drive_sel] <= cyl_q[drive_sel] - 8'h01;
            end
        end
    end

    // Track zero sensor of the selected drive
    assign trk0_pin = (cyl_q[drive_sel] == 8'h00);
    assign cyl0     = cyl_q[0];
endmodule : drive_model

// file: tb/floppy_seek_status_cmds_tb.sv
// Self-checking bench for the positioning and status command interpreter
`timescale 1ns/1ps
module floppy_seek_status_cmds_tb;
    logic        sys_clk, rst, ce, host_wr_valid, host_wr_ready, res_valid, res_rd;
    logic        int_out, step_out, dir_out, trk0_pin, wprot_pin, ready_pin, twosd_pin;
    logic        xfer_seek_req, xfer_seek_done, implied_seek_enable, seen;
    logic [7:0]  host_wr_data, res_data, xfer_seek_cyl, cyl0, tgt, code;
    logic [3:0]  drive_busy;
    logic [1:0]  drive_sel, xfer_seek_drive;
    logic [15:0] step_cnt, s0;
    logic [7:0]  exp_q [$];
    int          miscompares, n_checks, cyc, seed;

    floppy_seek_status_cmds uut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
        .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data),
        .host_wr_ready(host_wr_ready), .res_valid(res_valid), .res_data(res_data),
        .res_rd(res_rd), .int_out(int_out), .drive_busy(drive_busy), .step_out(step_out),
        .dir_out(dir_out), .drive_sel(drive_sel), .trk0_pin(trk0_pin),
        .wprot_pin(wprot_pin), .ready_pin(ready_pin), .twosd_pin(twosd_pin),
        .xfer_seek_req(xfer_seek_req), .xfer_seek_drive(xfer_seek_drive),
        .xfer_seek_cyl(xfer_seek_cyl), .xfer_seek_done(xfer_seek_done),
        .implied_seek_enable(implied_seek_enable));
    drive_model drive (.sys_clk(sys_clk), .rst(rst), .step_out(step_out), .dir_out(dir_out),
        .drive_sel(drive_sel), .trk0_pin(trk0_pin), .cyl0(cyl0), .step_cnt(step_cnt));

    // Clock of 8 ns period
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask : print_verdict

    task automatic chk(input logic ok, input string m);
        begin
            n_checks++;
            if (ok !== 1'b1)
            begin
                miscompares++;
                $display("BAD %0t %s", $time, m);
            end
        end
    endtask : chk

    // Offer n bytes, each held until the edge where ready is high
    task automatic cmd(input logic [7:0] b0, b1, b2, b3, input int n);
        logic [7:0] b [4];
        int         t;
        begin
            b = '{b0, b1, b2, b3};
            for (int i = 0; i < n; i++)
            begin
                host_wr_valid = 1'b1;
                host_wr_data  = b[i];
                t = 0;
                while (host_wr_ready !== 1'b1 && t < 100)
                begin
                    @(negedge sys_clk);
                    t++;
                end
                @(negedge sys_clk);
            end
            host_wr_valid = 1'b0;
            @(negedge sys_clk);
        end
    endtask : cmd

    // Pop n result bytes, one idle cycle between pops
    task automatic rdr(input int n);
        int t;
        begin
            for (int i = 0; i < n; i++)
            begin
                t = 0;
                while (res_valid !== 1'b1 && t < 100)
                begin
                    @(negedge sys_clk);
                    t++;
                end
                res_rd = 1'b1;
                @(negedge sys_clk);
                res_rd = 1'b0;
                @(negedge sys_clk);
            end
        end
    endtask : rdr

    // Bounded wait for a completion flag
    task automatic wait_for(input bit use_int, input int lim);
        begin
            seen = 1'b0;
            for (int t = 0; t < lim && seen !== 1'b1; t++)
            begin
                seen = use_int ? int_out : xfer_seek_done;
                if (seen !== 1'b1)
                    @(negedge sys_clk);
            end
        end
    endtask : wait_for

    // Compare each popped result byte with the oldest note
    always @(posedge sys_clk)
    begin
        if (res_valid === 1'b1 && res_rd === 1'b1)
        begin
            n_checks++;
            if (exp_q.size() == 0 || res_data !== exp_q[0])
            begin
                miscompares++;
                $display("BAD %0t result byte %h", $time, res_data);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        {host_wr_valid, res_rd, wprot_pin, ready_pin, twosd_pin, xfer_seek_req} = '0;
        {host_wr_data, xfer_seek_cyl, xfer_seek_drive} = '0;
        rst = 1'b1;
        ce  = 1'b1;
        seed = $urandom(55625);
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        chk(host_wr_ready === 1'b1 && int_out === 1'b0 && drive_busy === 4'h0, "reset");
        cmd(fdc_seek_pkg::OP_SPECIFY, 8'($urandom), 8'($urandom), 8'h00, 3);
        exp_q.push_back(fdc_seek_pkg::STAT_INVALID);
        cmd(fdc_seek_pkg::OP_SIS, 8'h00, 8'h00, 8'h00, 1);
        rdr(1);
        // Unknown code, then a byte offered during its result is refused
        do code = 8'($urandom);
        while (code inside {fdc_seek_pkg::OP_SPECIFY, fdc_seek_pkg::OP_SDS,
            fdc_seek_pkg::OP_RECAL, fdc_seek_pkg::OP_SIS, fdc_seek_pkg::OP_SEEK,
            fdc_seek_pkg::OP_CONFIGURE});
        exp_q.push_back(fdc_seek_pkg::STAT_INVALID);
        cmd(code, 8'h00, 8'h00, 8'h00, 1);
        repeat (2) @(negedge sys_clk);
        host_wr_valid = 1'b1;
        host_wr_data  = fdc_seek_pkg::OP_SIS;
        repeat (3) @(negedge sys_clk);
        host_wr_valid = 1'b0;
        rdr(1);
        chk(res_valid === 1'b0 && host_wr_ready === 1'b1, "result phase end");
        // Seek with head one to a random cylinder
        tgt = 8'($urandom_range(6, 1));
        s0  = step_cnt;
        cmd(fdc_seek_pkg::OP_SEEK, 8'h04, tgt, 8'h00, 3);
        repeat (6) @(negedge sys_clk);
        chk(drive_busy === 4'h1 && dir_out === 1'b1 && drive_sel === 2'h0,
            "seek busy");
        // Clock enable low freezes the seek in the middle of a step
        ce = 1'b0;
        repeat (400) @(negedge sys_clk);
        chk(step_out === 1'b1 && step_cnt - s0 === 16'h0001 && drive_busy === 4'h1,
            "freeze");
        ce = 1'b1;
        wait_for(1'b1, 5000);
        chk(cyl0 === tgt && step_cnt - s0 === 16'(tgt), "seek steps");
        chk(drive_busy === 4'h0, "seek busy end");
        exp_q.push_back(8'h24);
        exp_q.push_back(tgt);
        cmd(fdc_seek_pkg::OP_SIS, 8'h00, 8'h00, 8'h00, 1);
        rdr(2);
        chk(int_out === 1'b0 && exp_q.size() == 0, "sense interrupt");
        // Recalibrate back to track zero
        s0 = step_cnt;
        cmd(fdc_seek_pkg::OP_RECAL, 8'h00, 8'h00, 8'h00, 2);
        wait_for(1'b1, 5000);
        chk(seen === 1'b1 && cyl0 === 8'h00 && step_cnt - s0 === 16'(tgt), "recal");
        exp_q.push_back(fdc_seek_pkg::STAT_SEEK_END);
        exp_q.push_back(8'h00);
        cmd(fdc_seek_pkg::OP_SIS, 8'h00, 8'h00, 8'h00, 1);
        rdr(2);
        // Drive status with random pin levels
        {wprot_pin, ready_pin, twosd_pin} = 3'($urandom);
        repeat (10) @(negedge sys_clk);
        exp_q.push_back({1'b0, wprot_pin, ready_pin, 1'b1, twosd_pin, 3'h4});
        cmd(fdc_seek_pkg::OP_SDS, 8'h04, 8'h00, 8'h00, 2);
        rdr(1);
        // Implied seek refused, then enabled by configure
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1)
                cmd(fdc_seek_pkg::OP_CONFIGURE, 8'h00, 8'h40, 8'($urandom), 4);
            chk(implied_seek_enable === 1'(k), "configure");
            s0 = step_cnt;
            xfer_seek_cyl = 8'h03;
            xfer_seek_req = 1'b1;
            @(negedge sys_clk);
            xfer_seek_req = 1'b0;
            wait_for(1'b0, k == 0 ? 4 : 4000);
            chk(seen === 1'b1 && cyl0 === 8'(3 * k) && int_out === 1'b0, "implied");
        end
        print_verdict();
    end
endmodule : floppy_seek_status_cmds_tb
